/* File: include/i2c_slave_pkg.sv */
// Constants and state codes for the two-wire slave address engine
package i2c_slave_pkg;

  // ****************************************
  // State codes
  // ****************************************
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_ALO  = 5'b00100,
    S_RCV  = 5'b01000,
    S_XMIT = 5'b10000
  } slave_state_t;

  // ****************************************
  // Bit counter marks and address fields
  // ****************************************
  localparam logic [3:0] BIT_ZERO   = 4'h0;
  localparam logic [3:0] BIT_LAST   = 4'h7;
  localparam logic [3:0] BIT_ACK    = 4'h8;
  localparam logic [3:0] BIT_DONE   = 4'h9;
  localparam logic [4:0] TEN_PREFIX = 5'h1E;
  localparam int         RW_BIT     = 0;
  localparam logic [7:0] ADDR_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : i2c_slave_pkg

/* File: logic/i2c_slave_address_engine.sv */
// Slave-side address recognition, receive/transmit and clock stretching
module i2c_slave_address_engine
  import i2c_slave_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       arst_n,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       ten_bit_mode,
  input  wire logic       addr_wr,
  input  wire logic [7:0] addr_wdata,
  input  wire logic       tx_wr,
  input  wire logic [7:0] tx_wdata,
  input  wire logic       rx_rd,
  input  wire logic       ovf_clr,
  input  wire logic       clock_release_control,
  output logic            scl_o,
  output logic            scl_oe,
  output logic            sda_o,
  output logic            sda_oe,
  output logic [7:0]      serial_data_buffer,
  output logic            buf_full,
  output logic            tx_full,
  output logic            receive_overflow_flag,
  output logic            address_update_flag,
  output logic            full_address_matched,
  output logic            receive_state,
  output logic            transmit_state,
  output logic            irq_pulse
);

  // ****************************************
  // Registers
  // ****************************************
  logic [1:0]   scl_sync_r;
  logic [1:0]   sda_sync_r;
  logic         scl_p_r;
  logic         sda_p_r;
  slave_state_t state_r;
  slave_state_t pend_r;
  logic [3:0]   bit_cnt_r;
  logic [7:0]   serial_shift_register_r;
  logic [7:0]   rx_buf_r;
  logic [7:0]   tx_buf_r;
  logic [7:0]   slave_address_register_r;
  logic         buf_full_r;
  logic         tx_full_r;
  logic         ovf_r;
  logic         ua_r;
  logic         fam_r;
  logic         ack_r;
  logic         addr_hold_pend_r;
  logic         hold_addr_r;
  logic         hold_tx_r;
  logic         scl_oe_r;
  logic         sda_oe_r;
  logic         irq_r;

  // ****************************************
  // Bus event decode
  // ****************************************
  wire       scl_s      = scl_sync_r[1];
  wire       sda_s      = sda_sync_r[1];
  wire       scl_rise   = scl_s & ~scl_p_r;
  wire       scl_fall   = ~scl_s & scl_p_r;
  // Start and repeated start look alike on the wire
  wire       start_det  = scl_s & scl_p_r & sda_p_r & ~sda_s;
  wire       stop_det   = scl_s & scl_p_r & ~sda_p_r & sda_s;
  wire       edge_cond  = start_det | stop_det;
  wire [7:0] byte_in    = {serial_shift_register_r[6:0], sda_s};
  wire       byte_end   = scl_rise && (bit_cnt_r == BIT_LAST);
  wire       ack_sample = scl_rise && (bit_cnt_r == BIT_ACK);
  wire       ack_fall   = scl_fall && (bit_cnt_r == BIT_DONE);
  wire       in_xmit    = (state_r == S_XMIT);
  wire       tx_bit_fall = scl_fall && in_xmit && (bit_cnt_r != BIT_ZERO)
                           && (bit_cnt_r < BIT_ACK);
  wire       addr7_hit  = (byte_in[7:1] == slave_address_register_r[7:1]);
  wire       hi10_hit   = addr7_hit && (byte_in[7:3] == TEN_PREFIX);
  wire       lo_hit     = (byte_in == slave_address_register_r);
  wire       is_read    = byte_in[RW_BIT];
  wire       rx_blocked = buf_full_r | ovf_r;
  wire       in_addr7   = (state_r == S_ADDR) && !ten_bit_mode;
  wire       hi_wr      = (state_r == S_ADDR) && ten_bit_mode && hi10_hit && !is_read;
  wire       hi_rd      = (state_r == S_ADDR) && ten_bit_mode && hi10_hit && is_read;
  wire       tx_ready   = tx_full_r | clock_release_control;
  wire       tx_load    = (ack_fall && (pend_r == S_XMIT) && tx_ready && !hold_addr_r)
                          || (hold_tx_r && tx_ready);

  // ****************************************
  // Byte-end decision
  // ****************************************
  slave_state_t state_dec;
  logic ack_dec, irq_dec, ovf_set, ua_set, fam_set, fam_clr, rx_load, hold_dec;

  always_comb begin
    state_dec = S_IDLE;
    ack_dec   = 1'b0;
    irq_dec   = 1'b0;
    ovf_set   = 1'b0;
    ua_set    = 1'b0;
    fam_set   = 1'b0;
    fam_clr   = 1'b0;
    rx_load   = 1'b0;
    hold_dec  = 1'b0;
    case (state_r)
      S_ADDR: begin
        if (in_addr7 && addr7_hit) begin
          irq_dec   = 1'b1;
          ack_dec   = 1'b1;
          state_dec = is_read ? S_XMIT : S_RCV;
        end else if (hi_wr) begin
          irq_dec = 1'b1;
          fam_clr = 1'b1;
          if (rx_blocked) begin
            ovf_set = 1'b1;
          end else begin
            ua_set    = 1'b1;
            ack_dec   = 1'b1;
            hold_dec  = 1'b1;
            state_dec = S_ALO;
          end
        end else if (hi_rd) begin
          // Full match survives the repeated start
          if (fam_r) begin
            ack_dec   = 1'b1;
            state_dec = S_XMIT;
          end else begin
            fam_clr = 1'b1;
          end
        end
      end
      S_ALO: begin
        if (lo_hit) begin
          fam_set   = 1'b1;
          ack_dec   = 1'b1;
          ua_set    = 1'b1;
          hold_dec  = 1'b1;
          state_dec = S_RCV;
        end
      end
      S_RCV: begin
        irq_dec   = 1'b1;
        state_dec = S_RCV;
        if (rx_blocked) begin
          ovf_set = buf_full_r;
        end else begin
          rx_load = 1'b1;
          ack_dec = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_p_r    <= 1'b1;
      sda_p_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_p_r    <= scl_s;
      sda_p_r    <= sda_s;
    end
  end

  // ****************************************
  // Bit counter and state
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_r <= BIT_ZERO;
      state_r   <= S_IDLE;
      pend_r    <= S_IDLE;
      ack_r     <= 1'b0;
    end else begin
      if (edge_cond || ack_fall) begin
        bit_cnt_r <= BIT_ZERO;
      end else if (scl_rise) begin
        bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
      end
      if (stop_det) begin
        state_r <= S_IDLE;
      end else if (start_det) begin
        state_r <= S_ADDR;
      end else if (ack_fall) begin
        state_r <= pend_r;
      end
      if (byte_end && !in_xmit) begin
        pend_r <= state_dec;
        ack_r  <= ack_dec;
      end else if (ack_sample && in_xmit) begin
        pend_r <= sda_s ? S_IDLE : S_XMIT;
        ack_r  <= 1'b0;
      end
    end
  end

  // ****************************************
  // Shift register and buffers
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      serial_shift_register_r <= BYTE_RESET;
    end else if (tx_load) begin
      serial_shift_register_r <= tx_buf_r;
    end else if (scl_rise && (bit_cnt_r < BIT_ACK) && !in_xmit) begin
      serial_shift_register_r <= byte_in;
    end else if (tx_bit_fall) begin
      serial_shift_register_r <= {serial_shift_register_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf_r                 <= BYTE_RESET;
      tx_buf_r                 <= BYTE_RESET;
      slave_address_register_r <= ADDR_RESET;
      buf_full_r               <= 1'b0;
      tx_full_r                <= 1'b0;
      ovf_r                    <= 1'b0;
      ua_r                     <= 1'b0;
      fam_r                    <= 1'b0;
      irq_r                    <= 1'b0;
    end else begin
      irq_r <= byte_end && irq_dec;
      if (byte_end && rx_load) rx_buf_r <= byte_in;
      if (tx_wr) tx_buf_r <= tx_wdata;
      if (addr_wr) slave_address_register_r <= addr_wdata;
      // Hardware sets win over software clears
      if (byte_end && rx_load) buf_full_r <= 1'b1;
      else if (rx_rd) buf_full_r <= 1'b0;
      if (tx_wr) tx_full_r <= 1'b1;
      else if (tx_load) tx_full_r <= 1'b0;
      if (byte_end && ovf_set) ovf_r <= 1'b1;
      else if (ovf_clr) ovf_r <= 1'b0;
      if (byte_end && ua_set) ua_r <= 1'b1;
      else if (addr_wr) ua_r <= 1'b0;
      if (byte_end && fam_set) fam_r <= 1'b1;
      else if (byte_end && fam_clr) fam_r <= 1'b0;
    end
  end

  // ****************************************
  // Clock stretching and data drive
  // ****************************************
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      addr_hold_pend_r <= 1'b0;
      hold_addr_r      <= 1'b0;
      hold_tx_r        <= 1'b0;
      scl_oe_r         <= 1'b0;
    end else begin
      if (byte_end && !in_xmit) addr_hold_pend_r <= hold_dec;
      if (edge_cond || addr_wr) begin
        hold_addr_r <= 1'b0;
      end else if (ack_fall && addr_hold_pend_r) begin
        hold_addr_r <= 1'b1;
      end
      if (edge_cond || tx_ready) begin
        hold_tx_r <= 1'b0;
      end else if (ack_fall && (pend_r == S_XMIT)) begin
        hold_tx_r <= 1'b1;
      end
      scl_oe_r <= !edge_cond && !addr_wr && (hold_addr_r || (ack_fall && addr_hold_pend_r))
                  || !edge_cond && !tx_ready && (hold_tx_r || (ack_fall && pend_r == S_XMIT));
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sda_oe_r <= 1'b0;
    end else if (edge_cond) begin
      sda_oe_r <= 1'b0;
    end else if (tx_load) begin
      sda_oe_r <= ~tx_buf_r[7];
    end else if (ack_fall) begin
      sda_oe_r <= 1'b0;
    end else if (scl_fall && (bit_cnt_r == BIT_ACK)) begin
      sda_oe_r <= ack_r && !in_xmit;
    end else if (tx_bit_fall) begin
      sda_oe_r <= ~serial_shift_register_r[6];
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign scl_o                 = 1'b0;
  assign sda_o                 = 1'b0;
  assign scl_oe                = scl_oe_r;
  assign sda_oe                = sda_oe_r;
  assign serial_data_buffer    = rx_buf_r;
  assign buf_full              = buf_full_r;
  assign tx_full               = tx_full_r;
  assign receive_overflow_flag = ovf_r;
  assign address_update_flag   = ua_r;
  assign full_address_matched  = fam_r;
  assign receive_state         = state_r[3];
  assign transmit_state        = state_r[4];
  assign irq_pulse             = irq_r;

  // ****************************************
  // Assertions
  // ****************************************
  property p_read_first;
    @(posedge mclk) disable iff (!arst_n)
    ack_fall && pend_r == S_XMIT && tx_full_r && !hold_addr_r && !edge_cond
      |=> sda_oe_r == !$past(tx_buf_r[7]) && tx_full_r == $past(tx_wr);
  endproperty
  a_read_first: assert property (p_read_first) else $error("First read bit not driven");

  property p_addr7_read;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && in_addr7 && addr7_hit && is_read |=> pend_r == S_XMIT && ack_r && irq_r;
  endproperty
  a_addr7_read: assert property (p_addr7_read) else $error("7-bit read match mishandled");

  property p_addr7_write;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && in_addr7 && addr7_hit && !is_read |=> pend_r == S_RCV ##[1:400] ack_fall;
  endproperty
  a_addr7_write: assert property (p_addr7_write) else $error("7-bit write match mishandled");

  property p_rx_nack;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && state_r == S_RCV && rx_blocked |=> !ack_r && $stable(rx_buf_r);
  endproperty
  a_rx_nack: assert property (p_rx_nack) else $error("Blocked byte acknowledged");

  property p_rx_ack;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && state_r == S_RCV && !rx_blocked
      |=> ack_r && buf_full_r && rx_buf_r == $past(byte_in);
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("Received byte not stored");

  property p_rx_irq;
    @(posedge mclk) disable iff (!arst_n)
    $rose(irq_r) |-> $past(bit_cnt_r) == BIT_LAST && $past(scl_rise);
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("Interrupt not at eighth bit");

  property p_tx_hold;
    @(posedge mclk) disable iff (!arst_n)
    hold_tx_r && !tx_ready && !edge_cond |=> scl_oe_r && hold_tx_r;
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("Clock not held for empty buffer");

  property p_tx_nack;
    @(posedge mclk) disable iff (!arst_n)
    ack_sample && in_xmit && sda_s |=> pend_r == S_IDLE;
  endproperty
  a_tx_nack: assert property (p_tx_nack) else $error("Not-acknowledge did not end transmit");

  property p_tx_ack;
    @(posedge mclk) disable iff (!arst_n)
    ack_sample && in_xmit && !sda_s |=> pend_r == S_XMIT;
  endproperty
  a_tx_ack: assert property (p_tx_ack) else $error("Acknowledge left transmit");

  property p_hi_ovf;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && hi_wr && rx_blocked |=> ovf_r && !ack_r && irq_r;
  endproperty
  a_hi_ovf: assert property (p_hi_ovf) else $error("High byte overflow mishandled");

  property p_hi_irq;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && hi_wr && !rx_blocked |=> irq_r && ua_r && ack_r;
  endproperty
  a_hi_irq: assert property (p_hi_irq) else $error("High byte match mishandled");

  property p_ua_clr;
    @(posedge mclk) disable iff (!arst_n)
    hold_addr_r && addr_wr && !byte_end |=> !ua_r && !hold_addr_r ##1 !scl_oe_r || hold_tx_r;
  endproperty
  a_ua_clr: assert property (p_ua_clr) else $error("Update flag or hold not cleared");

  property p_lo_match;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && state_r == S_ALO && lo_hit |=> fam_r && ack_r && ua_r && addr_hold_pend_r;
  endproperty
  a_lo_match: assert property (p_lo_match) else $error("Low byte match mishandled");

  property p_hi_read;
    @(posedge mclk) disable iff (!arst_n)
    byte_end && hi_rd |=> (ack_r && pend_r == S_XMIT) == $past(fam_r) && fam_r == $past(fam_r);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("High byte read mishandled");

  property p_release;
    @(posedge mclk) disable iff (!arst_n)
    hold_addr_r && !addr_wr && !edge_cond |=> hold_addr_r && scl_oe_r;
  endproperty
  a_release: assert property (p_release) else $error("Clock released without rewrite");

endmodule : i2c_slave_address_engine

/* File: test/i2c_master_model.sv */
// Behavioural two-wire bus master for the slave address engine bench
module i2c_master_model (
  input  wire logic scl_line,
  input  wire logic sda_line,
  output logic      scl_low,
  output logic      sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************
  // Line control
  // ****************************************
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end

  // Release clock, then wait out a slave stretch under a bound
  task automatic scl_up();
    int n;
    n = 0;
    scl_low = 1'b0;
    while (scl_line !== 1'b1 && n < 20000) begin
      #5;
      n++;
    end
  endtask : scl_up

  // Data changes only while clock is low
  task automatic clk_bit(input logic b, output logic r);
    sda_low = ~b;
    #16;
    scl_up();
    #32;
    r = sda_line;
    scl_low = 1'b1;
    #16;
  endtask : clk_bit

  // Also serves as repeated start right after an ack pulse
  task automatic start_cond();
    sda_low = 1'b0;
    #16;
    scl_up();
    #32;
    sda_low = 1'b1;
    #32;
    scl_low = 1'b1;
    #16;
  endtask : start_cond

  task automatic stop_cond();
    sda_low = 1'b1;
    #16;
    scl_up();
    #32;
    sda_low = 1'b0;
    #32;
  endtask : stop_cond

  // Byte out MSB first, returns the sampled acknowledge bit
  task automatic wbyte(input logic [7:0] v, output logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(v[i], r);
    end
    clk_bit(1'b1, nack);
  endtask : wbyte

  task automatic rbyte(input logic nack, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b1, r);
      v[i] = r;
    end
    clk_bit(nack, r);
  endtask : rbyte

endmodule : i2c_master_model

/* File: test/i2c_slave_address_engine_tb_top.sv */
// Self-checking bench for the two-wire slave address engine
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end

module i2c_slave_address_engine_tb_top;
  import i2c_slave_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic       mclk, arst_n, ten_bit_mode, addr_wr, tx_wr, rx_rd, ovf_clr;
  logic       clock_release_control, scl_low, sda_low, nk;
  logic [7:0] addr_wdata, tx_wdata, rd;
  logic       scl_o, scl_oe, sda_o, sda_oe, buf_full, tx_full, receive_overflow_flag;
  logic       address_update_flag, full_address_matched, receive_state;
  logic       transmit_state, irq_pulse;
  logic [7:0] serial_data_buffer;
  wire        scl_line = ~(scl_low | scl_oe);
  wire        sda_line = ~(sda_low | sda_oe);
  int         err_total, checks, irq_cnt, irq_ref;

  i2c_slave_address_engine i2c_slave_address_engine_i (
    .mclk(mclk), .arst_n(arst_n), .scl_i(scl_line), .sda_i(sda_line),
    .ten_bit_mode(ten_bit_mode), .addr_wr(addr_wr), .addr_wdata(addr_wdata),
    .tx_wr(tx_wr), .tx_wdata(tx_wdata), .rx_rd(rx_rd), .ovf_clr(ovf_clr),
    .clock_release_control(clock_release_control), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_o(sda_o), .sda_oe(sda_oe), .serial_data_buffer(serial_data_buffer),
    .buf_full(buf_full), .tx_full(tx_full), .receive_overflow_flag(receive_overflow_flag),
    .address_update_flag(address_update_flag), .full_address_matched(full_address_matched),
    .receive_state(receive_state), .transmit_state(transmit_state), .irq_pulse(irq_pulse));

  i2c_master_model i2c_master_model_i (
    .scl_line(scl_line), .sda_line(sda_line), .scl_low(scl_low), .sda_low(sda_low));

  // ****************************************
  // Clock, event counter and helpers
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk) begin
    if (irq_pulse === 1'b1) irq_cnt <= irq_cnt + 1;
  end

  // Software side: 0 address, 1 tx load, 2 buffer read, 3 overflow clear
  task automatic sw(input int k, input logic [7:0] v);
    @(posedge mclk);
    addr_wdata <= v;
    tx_wdata   <= v;
    addr_wr    <= (k == 0);
    tx_wr      <= (k == 1);
    rx_rd      <= (k == 2);
    ovf_clr    <= (k == 3);
    @(posedge mclk);
    {addr_wr, tx_wr, rx_rd, ovf_clr} <= 4'h0;
  endtask : sw

  task automatic settle();
    repeat (8) @(posedge mclk);
    #1;
  endtask : settle

  task automatic irq_step(input int n); // expected new events since last call
    `CHK(irq_cnt - irq_ref, n)
    irq_ref = irq_cnt;
  endtask : irq_step

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_write7();
    sw(0, 8'hA0);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hA0, nk);
    `CHK(nk, 1'b0)
    settle();
    `CHK(receive_state, 1'b1)
    irq_step(1);
    i2c_master_model_i.wbyte(8'hC3, nk);
    `CHK(nk, 1'b0)
    settle();
    `CHK(serial_data_buffer, 8'hC3)
    `CHK(buf_full, 1'b1)
    irq_step(1);
    i2c_master_model_i.wbyte(8'h3C, nk);
    `CHK(nk, 1'b1)
    settle();
    `CHK(serial_data_buffer, 8'hC3)
    `CHK(receive_overflow_flag, 1'b1)
    i2c_master_model_i.stop_cond();
    irq_ref = irq_cnt;
  endtask : t_write7

  task automatic t_ten_ovf(); // buffer still full here
    ten_bit_mode <= 1'b1;
    sw(3, 8'h00);
    sw(0, 8'hF4);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hF4, nk);
    `CHK(nk, 1'b1)
    settle();
    `CHK(receive_overflow_flag, 1'b1)
    irq_step(1);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hF5, nk);
    `CHK(nk, 1'b1)
    i2c_master_model_i.stop_cond();
    sw(2, 8'h00);
    sw(3, 8'h00);
    settle();
    `CHK({buf_full, receive_overflow_flag}, 2'b00)
    irq_ref = irq_cnt;
  endtask : t_ten_ovf

  task automatic t_read7(); // also an unmatched address first
    ten_bit_mode <= 1'b0;
    sw(0, 8'hA0);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'h52, nk);
    `CHK(nk, 1'b1)
    i2c_master_model_i.stop_cond();
    irq_step(0);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hA1, nk);
    `CHK(nk, 1'b0)
    repeat (20) @(posedge mclk);
    `CHK(transmit_state, 1'b1)
    `CHK(scl_oe, 1'b1)
    irq_step(1);
    sw(1, 8'h5A);
    i2c_master_model_i.rbyte(1'b0, rd);
    `CHK(rd, 8'h5A)
    settle();
    `CHK(transmit_state, 1'b1)
    sw(1, 8'h81);
    i2c_master_model_i.rbyte(1'b1, rd);
    `CHK(rd, 8'h81)
    settle();
    `CHK({transmit_state, scl_oe, tx_full}, 3'b000)
    i2c_master_model_i.stop_cond();
    irq_ref = irq_cnt;
  endtask : t_read7

  task automatic t_ten(); // full address as write, then read
    ten_bit_mode <= 1'b1;
    sw(0, 8'hF4);
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hF4, nk);
    `CHK(nk, 1'b0)
    repeat (20) @(posedge mclk);
    `CHK({address_update_flag, scl_oe}, 2'b11)
    irq_step(1);
    sw(0, 8'h33);
    settle();
    `CHK({address_update_flag, scl_oe}, 2'b00)
    i2c_master_model_i.wbyte(8'h33, nk);
    `CHK(nk, 1'b0)
    settle();
    `CHK({full_address_matched, address_update_flag, scl_oe}, 3'b111)
    sw(0, 8'hF4);
    sw(1, 8'h96);
    settle();
    `CHK({address_update_flag, scl_oe, tx_full}, 3'b001)
    i2c_master_model_i.start_cond();
    i2c_master_model_i.wbyte(8'hF5, nk);
    `CHK(nk, 1'b0)
    settle();
    `CHK({transmit_state, scl_oe, tx_full}, 3'b100)
    @(posedge mclk);
    clock_release_control <= 1'b1;
    i2c_master_model_i.rbyte(1'b0, rd);
    `CHK(rd, 8'h96)
    // Release control set: no stretch, buffer contents sent again
    i2c_master_model_i.rbyte(1'b1, rd);
    `CHK(rd, 8'h96)
    settle();
    `CHK({transmit_state, scl_oe}, 2'b00)
    i2c_master_model_i.stop_cond();
    @(posedge mclk);
    clock_release_control <= 1'b0;
  endtask : t_ten

  // ****************************************
  // Sequence and verdict
  // ****************************************
  task automatic give_verdict();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {arst_n, ten_bit_mode, addr_wr, tx_wr, rx_rd, ovf_clr} = 6'h00;
    clock_release_control = 1'b0;
    addr_wdata = 8'h00;
    tx_wdata = 8'h00;
    {err_total, checks, irq_cnt, irq_ref} = '0;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    settle();
    `CHK({receive_state, transmit_state, buf_full, scl_oe, sda_oe}, 5'h00)
    `CHK({scl_o, sda_o, tx_full, address_update_flag, full_address_matched}, 5'h00)
    t_write7();
    t_ten_ovf();
    t_read7();
    t_ten();
    give_verdict();
  end

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

endmodule : i2c_slave_address_engine_tb_top
